// ---- verification/chan_select_chk.sv ----
// port assertions for the channel selection block
`timescale 1ns/1ps
`default_nettype none
module chan_select_chk #(
   parameter logic [1:0] VARIANT = chan_select_pkg::VAR_SECOND_GEN,
   parameter int         ADDR_W  = 12
) (
   // clock and reset
   input wire logic              pclk,
   input wire logic              presetn,
   // apb
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   // sequencer side
   input wire logic [5:0]        adc_channel_code,
   input wire logic [4:0]        fast_slot,
   input wire logic              fast_valid,
   input wire logic [5:0]        slow_channel_code,
   input wire logic              slow_valid,
   input wire logic              cal_in_fast,
   input wire logic              cal_in_slow
);
   localparam logic [ADDR_W-1:0] A_INT  = ADDR_W'({chan_select_pkg::IDX_SLOW_INT, 2'b00});
   localparam logic [ADDR_W-1:0] A_USER = ADDR_W'({chan_select_pkg::IDX_SLOW_USER, 2'b00});
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // a completed read without error
   sequence s_read_ok;
      pready && !pwrite && !pslverr;
   endsequence
   sequence s_fast_on(logic [5:0] c);
      fast_valid && adc_channel_code == c;
   endsequence
   // slot figures hold for the second generation part only
   property p_upper_zero; s_read_ok |-> prdata[31:16] == 16'h0000; endproperty
   property p_int_loose; s_read_ok ##0 (paddr == A_INT) |-> prdata[4:1] == 4'h0 && !prdata[15]; endproperty
   property p_user_loose; s_read_ok ##0 (paddr == A_USER) |-> prdata[15:4] == 12'h000; endproperty
   property p_cal_override; cal_in_fast && $past(cal_in_fast) |-> !cal_in_slow; endproperty
   property p_reset_cal; $rose(presetn) |=> cal_in_slow && slow_valid && slow_channel_code == 6'h08; endproperty
   property p_slot_pos; s_fast_on(6'h04) |-> fast_slot == 5'd5; endproperty
   property p_slot_neg; s_fast_on(6'h05) |-> fast_slot == 5'd6; endproperty
   property p_slot_bram; s_fast_on(6'h06) |-> fast_slot == 5'd7; endproperty
   property p_slot_user;
      fast_valid && adc_channel_code[5:2] == 4'h8 |-> fast_slot == adc_channel_code[4:0] - 5'd8;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");
   a_int_loose: assert property (p_int_loose) else $error("loose internal bits set");
   a_user_loose: assert property (p_user_loose) else $error("loose user bits set");
   a_cal_override: assert property (p_cal_override) else $error("calibration in both");
   a_reset_cal: assert property (p_reset_cal) else $error("no calibration after reset");
   a_slot_pos: assert property (p_slot_pos) else $error("positive reference slot");
   a_slot_neg: assert property (p_slot_neg) else $error("negative reference slot");
   a_slot_bram: assert property (p_slot_bram) else $error("block ram supply slot");
   a_slot_user: assert property (p_slot_user) else $error("user supply slot");
endmodule : chan_select_chk
bind chan_select chan_select_chk #(.VARIANT(VARIANT), .ADDR_W(ADDR_W)) u_chan_select_chk (
   .pclk(pclk), .presetn(presetn), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .adc_channel_code(adc_channel_code), .fast_slot(fast_slot), .fast_valid(fast_valid),
   .slow_channel_code(slow_channel_code), .slow_valid(slow_valid), .cal_in_fast(cal_in_fast),
   .cal_in_slow(cal_in_slow));
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the channel selection block
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, wd;
   logic        pready, pslverr, fast_valid, slow_valid, cal_in_fast, cal_in_slow, er;
   logic        fast_advance = 1'b0, slow_advance = 1'b0;
   logic [5:0]  adc_channel_code, slow_channel_code, c1;
   logic [4:0]  fast_slot;
   int          n_mismatch = 0, n_checks = 0, seed = 10;
   // register table: index, writable mask, reset value
   logic [7:0]  ridx [6] = '{chan_select_pkg::IDX_FAST_USER, chan_select_pkg::IDX_FAST_INT,
      chan_select_pkg::IDX_FAST_AUX, chan_select_pkg::IDX_SLOW_INT, chan_select_pkg::IDX_SLOW_AUX,
      chan_select_pkg::IDX_SLOW_USER};
   logic [15:0] rmsk [6] = '{16'h000f, 16'h7fe1, 16'hffff, 16'h7fe1, 16'hffff, 16'h000f};
   logic [15:0] rrst [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0000};
   // fast corner cases: internal, user, expected code and slot
   logic [15:0] fint [5] = '{16'h1000, 16'h2000, 16'h4000, 16'h0000, 16'h0000};
   logic [15:0] fusr [5] = '{16'h0000, 16'h0000, 16'h0000, 16'h0008, 16'h0001};
   logic [10:0] fexp [5] = '{{6'h04, 5'd5}, {6'h05, 5'd6}, {6'h06, 5'd7}, {6'h23, 5'd27}, {6'h20, 5'd24}};

   chan_select u_chan_select (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fast_advance(fast_advance), .slow_advance(slow_advance), .adc_channel_code(adc_channel_code),
      .fast_slot(fast_slot), .fast_valid(fast_valid), .slow_channel_code(slow_channel_code),
      .slow_valid(slow_valid), .cal_in_fast(cal_in_fast), .cal_in_slow(cal_in_slow));

   initial begin
      forever #5 pclk = ~pclk;
   end

   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : conclude

   // one apb transfer; the wait state count is not assumed
   task automatic apb(logic [7:0] idx, logic [1:0] lo, logic wr, logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, lo};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         #1;
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) n_mismatch++;
      rd = prdata;
      er = pslverr;
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // the walker drops a removed entry and rescans a cycle later, so wait for valid
   task automatic settle(logic slow);
      int n;
      n = 0;
      repeat (3) @(posedge pclk);
      while ((slow ? slow_valid : fast_valid) !== 1'b1 && n < 40) begin
         @(posedge pclk);
         n++;
      end
      #1;
   endtask : settle

   task automatic step(logic slow);
      @(posedge pclk);
      if (slow) slow_advance <= 1'b1;
      else fast_advance <= 1'b1;
      @(posedge pclk);
      slow_advance <= 1'b0;
      fast_advance <= 1'b0;
      @(posedge pclk);
      #1;
   endtask : step

   // slow code of bit b of the {user, aux, internal} vector; 3f marks no channel
   function automatic logic [5:0] slow_code(int b);
      if (b == 0) return 6'h08;
      if (b >= 5 && b <= 7) return 6'(b + 8);
      if (b >= 8 && b <= 14) return 6'(b - 8);
      if (b >= 16 && b < 36) return 6'(b);
      return 6'h3f;
   endfunction : slow_code

   initial begin
      #500000;
      n_mismatch++;
      conclude();
   end

   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         apb(ridx[i], 2'h0, 1'b0, 32'h0);
         check("reset value", rd, {16'h0, rrst[i]});
      end
      check("slow cal", {slow_valid, cal_in_slow, slow_channel_code}, {2'b11, 6'h08});
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         for (int j = 0; j < 4; j++) begin
            wd = (j == 0) ? 32'hffffffff : (j == 1) ? 32'h0 : $random(seed);
            apb(ridx[i], 2'h0, 1'b1, wd);
            check("write err", er, 1'b0);
            apb(ridx[i], 2'h0, 1'b0, 32'h0);
            check("readback", rd, wd & {16'h0, rmsk[i]});
         end
         apb(ridx[i], 2'h0, 1'b1, {16'h0, rrst[i]});
      end
      $display("test readback done");
      apb(8'h7d, 2'h0, 1'b1, 32'hffff);
      check("unmapped err", er, 1'b1);
      apb(8'h7d, 2'h0, 1'b0, 32'h0);
      check("unmapped data", rd, 32'h0);
      apb(chan_select_pkg::IDX_SLOW_INT, 2'h1, 1'b1, 32'h0);
      check("misaligned err", er, 1'b1);
      apb(chan_select_pkg::IDX_SLOW_INT, 2'h0, 1'b0, 32'h0);
      check("kept value", rd, 32'h1);
      $display("test refusal done");
      for (int k = 0; k < 5; k++) begin
         apb(chan_select_pkg::IDX_FAST_INT, 2'h0, 1'b1, {16'h0, fint[k]});
         apb(chan_select_pkg::IDX_FAST_USER, 2'h0, 1'b1, {16'h0, fusr[k]});
         settle(1'b0);
         check("fast code slot", {adc_channel_code, fast_slot}, fexp[k]);
      end
      apb(chan_select_pkg::IDX_FAST_USER, 2'h0, 1'b1, 32'h0);
      apb(chan_select_pkg::IDX_FAST_INT, 2'h0, 1'b1, 32'h1);
      settle(1'b0);
      check("cal fast", {cal_in_fast, cal_in_slow, adc_channel_code, fast_slot}, {2'b10, 6'h08, 5'd1});
      apb(chan_select_pkg::IDX_FAST_INT, 2'h0, 1'b1, 32'h3000);
      settle(1'b0);
      check("cal back", {cal_in_fast, cal_in_slow}, 2'b01);
      c1 = adc_channel_code;
      step(1'b0);
      check("fast pair", {c1[5:1], adc_channel_code}, {5'h02, c1 ^ 6'h01});
      apb(chan_select_pkg::IDX_FAST_INT, 2'h0, 1'b1, 32'h0);
      $display("test fast done");
      for (int b = 0; b < 48; b++) begin
         if (slow_code(b) != 6'h3f) begin
            wd = 32'h1 << b[3:0];
            apb(chan_select_pkg::IDX_SLOW_INT, 2'h0, 1'b1, (b < 16) ? wd : 32'h0);
            apb(chan_select_pkg::IDX_SLOW_AUX, 2'h0, 1'b1, (b / 16 == 1) ? wd : 32'h0);
            apb(chan_select_pkg::IDX_SLOW_USER, 2'h0, 1'b1, (b >= 32) ? wd : 32'h0);
            settle(1'b1);
            // processor supplies are not in the order of the default variant, so nothing is sequenced
            if (b >= 5 && b <= 7)
               check("slow absent", slow_valid, 1'b0);
            else
               check("slow code", slow_channel_code, slow_code(b));
         end
      end
      apb(chan_select_pkg::IDX_SLOW_INT, 2'h0, 1'b1, 32'h0300);
      apb(chan_select_pkg::IDX_SLOW_USER, 2'h0, 1'b1, 32'h0);
      settle(1'b1);
      c1 = slow_channel_code;
      step(1'b1);
      check("slow pair", {c1[5:1], slow_channel_code}, {5'h00, c1 ^ 6'h01});
      // enable low must freeze the walker even when an advance arrives
      ce <= 1'b0;
      c1 = slow_channel_code;
      step(1'b1);
      check("frozen code", slow_channel_code, c1);
      ce <= 1'b1;
      $display("test slow done");
      conclude();
   end
endmodule : tb
`default_nettype wire

// ---- verilog/chan_select.sv ----
// channel selection registers and sequence order walker for the monitor adc
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module chan_select #(
   parameter logic [1:0] VARIANT = chan_select_pkg::VAR_SECOND_GEN,
   parameter int         ADDR_W  = 12
) (
   // clock, reset, enable
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              ce,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // sequencer engine handshake
   input  wire logic              fast_advance,
   input  wire logic              slow_advance,
   output logic      [5:0]        adc_channel_code,
   output logic      [4:0]        fast_slot,
   output logic                   fast_valid,
   output logic      [5:0]        slow_channel_code,
   output logic                   slow_valid,
   output logic                   cal_in_fast,
   output logic                   cal_in_slow
);

   localparam bit HAS_SLOW = (VARIANT != chan_select_pkg::VAR_FIRST_GEN);

   typedef enum logic [2:0] {
      BUS_IDLE   = 3'b001,
      BUS_ACCESS = 3'b010,
      BUS_DONE   = 3'b100
   } bus_state_t;

   // register storage
   logic [15:0] fast_user_q, fast_int_q, fast_aux_q;
   logic [15:0] slow_int_q, slow_aux_q, slow_user_q;
   bus_state_t  bus_q;
   logic [31:0] prdata_q;
   logic        pready_q, pslverr_q;

   // walker state
   logic [4:0]  fast_ptr_q, slow_ptr_q;
   logic [5:0]  fast_code_q, slow_code_q;
   logic [4:0]  fast_slot_q;
   logic        fast_valid_q, slow_valid_q;
   logic        cal_fast_q, cal_slow_q;

   // entry present in the order of this variant; gen2 lets calibration share slot one
   function automatic bit entry_in_order(input int e);
      if (e == chan_select_pkg::E_CAL)
         return VARIANT == chan_select_pkg::VAR_FIRST_GEN;
      if (e >= chan_select_pkg::E_PS_FIRST && e <= chan_select_pkg::E_PS_LAST)
         return VARIANT == chan_select_pkg::VAR_SECOND_PROC;
      return 1'b1;
   endfunction : entry_in_order

   // slot number of an entry: one plus present entries ahead of it
   function automatic logic [4:0] slot_of(input logic [4:0] e);
      logic [4:0] n;
      n = chan_select_pkg::SLOT_FIRST;
      for (int i = 0; i < chan_select_pkg::N_ENTRY; i++) begin
         if (i < int'(e) && entry_in_order(i))
            n = n + 5'h01;
      end
      return n;
   endfunction : slot_of

   // next enabled entry after cur, wrapping; found is low when none is enabled
   function automatic logic [5:0] next_entry(input logic [chan_select_pkg::N_ENTRY-1:0] en,
                                             input logic [4:0] cur);
      logic       found;
      logic [4:0] idx;
      found = 1'b0;
      idx   = chan_select_pkg::ENTRY_NONE;
      for (int i = chan_select_pkg::N_ENTRY - 1; i >= 0; i--) begin
         if (en[i] && i > int'(cur)) begin
            found = 1'b1;
            idx   = 5'(i);
         end
      end
      if (!found) begin
         for (int i = chan_select_pkg::N_ENTRY - 1; i >= 0; i--) begin
            if (en[i]) begin
               found = 1'b1;
               idx   = 5'(i);
            end
         end
      end
      return {found, idx};
   endfunction : next_entry

   // address decode: word aligned index compare
   function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
      logic [7:0] idx;
      idx = a[chan_select_pkg::IDX_LSB +: 8];
      if (a[1:0] != 2'h0 || a[ADDR_W-1:chan_select_pkg::IDX_LSB+8] != '0)
         return 3'h0;
      case (idx)
         chan_select_pkg::IDX_FAST_USER: return 3'h1;
         chan_select_pkg::IDX_FAST_INT:  return 3'h2;
         chan_select_pkg::IDX_FAST_AUX:  return 3'h3;
         chan_select_pkg::IDX_SLOW_INT:  return HAS_SLOW ? 3'h4 : 3'h0;
         chan_select_pkg::IDX_SLOW_AUX:  return HAS_SLOW ? 3'h5 : 3'h0;
         chan_select_pkg::IDX_SLOW_USER: return HAS_SLOW ? 3'h6 : 3'h0;
         default:                        return 3'h0;
      endcase
   endfunction : reg_sel

   logic [2:0]  sel;
   logic        wr_commit;
   logic [31:0] rd_mux;

   assign sel       = reg_sel(paddr);
   assign wr_commit = (bus_q == BUS_ACCESS) && psel && penable && pwrite && (sel != 3'h0);

   // read mux; unwritable bits are zero because storage never holds them
   always_comb begin
      case (sel)
         3'h1:    rd_mux = {16'h0000, fast_user_q};
         3'h2:    rd_mux = {16'h0000, fast_int_q};
         3'h3:    rd_mux = {16'h0000, fast_aux_q};
         3'h4:    rd_mux = {16'h0000, slow_int_q};
         3'h5:    rd_mux = {16'h0000, slow_aux_q};
         3'h6:    rd_mux = {16'h0000, slow_user_q};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // apb handshake: two wait cycles, answer registered so ports come from flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_q     <= BUS_IDLE;
         prdata_q  <= 32'h0000_0000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else if (ce) begin
         case (bus_q)
            BUS_IDLE: begin
               pready_q  <= 1'b0;
               pslverr_q <= 1'b0;
               if (psel && penable)
                  bus_q <= BUS_ACCESS;
            end
            BUS_ACCESS: begin
               pready_q  <= 1'b1;
               pslverr_q <= (sel == 3'h0);
               prdata_q  <= pwrite ? 32'h0000_0000 : rd_mux;
               bus_q     <= BUS_DONE;
            end
            BUS_DONE: begin
               pready_q  <= 1'b0;
               pslverr_q <= 1'b0;
               bus_q     <= BUS_IDLE;
            end
            default: begin
               bus_q    <= BUS_IDLE;
               pready_q <= 1'b0;
            end
         endcase
      end
   end

   // fast selection storage; the write lands on the same edge that raises pready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fast_user_q <= chan_select_pkg::RST_FAST;
         fast_int_q  <= chan_select_pkg::RST_FAST;
         fast_aux_q  <= chan_select_pkg::RST_FAST;
      end else if (ce && wr_commit) begin
         if (sel == 3'h1)
            fast_user_q <= pwdata[15:0] & chan_select_pkg::MASK_USER;
         if (sel == 3'h2)
            fast_int_q  <= pwdata[15:0] & chan_select_pkg::MASK_INT;
         if (sel == 3'h3)
            fast_aux_q  <= pwdata[15:0] & chan_select_pkg::MASK_AUX;
      end
   end

   // slow selection storage; absent on first generation so it stays at reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slow_int_q  <= chan_select_pkg::RST_SLOW_INT;
         slow_aux_q  <= chan_select_pkg::RST_SLOW_OTHER;
         slow_user_q <= chan_select_pkg::RST_SLOW_OTHER;
      end else if (ce && wr_commit) begin
         if (sel == 3'h4)
            slow_int_q  <= pwdata[15:0] & chan_select_pkg::MASK_INT;
         if (sel == 3'h5)
            slow_aux_q  <= pwdata[15:0] & chan_select_pkg::MASK_AUX;
         if (sel == 3'h6)
            slow_user_q <= pwdata[15:0] & chan_select_pkg::MASK_USER;
      end
   end

   // per-entry enables from the {user, aux, internal} vectors
   logic [47:0]                        fast_vec, slow_vec;
   logic [chan_select_pkg::N_ENTRY-1:0] fast_en, slow_en;
   logic                                fast_cal_bit;

   assign fast_vec     = {fast_user_q, fast_aux_q, fast_int_q};
   assign slow_vec     = {slow_user_q, slow_aux_q, slow_int_q};
   assign fast_cal_bit = fast_int_q[chan_select_pkg::BIT_CAL];

   generate
      for (genvar g = 0; g < chan_select_pkg::N_ENTRY; g++) begin : g_entry
         localparam bit IS_CAL = (g == chan_select_pkg::E_CAL);
         localparam bit IS_PS  = (g >= chan_select_pkg::E_PS_FIRST) && (g <= chan_select_pkg::E_PS_LAST);
         localparam bit PRESENT = !IS_PS || (VARIANT == chan_select_pkg::VAR_SECOND_PROC);
         assign fast_en[g] = PRESENT && fast_vec[chan_select_pkg::ENTRY_BIT[g]];
         // fast calibration enable wins over the slow one
         assign slow_en[g] = HAS_SLOW && PRESENT && slow_vec[chan_select_pkg::ENTRY_BIT[g]] &&
                             !(IS_CAL && fast_cal_bit);
      end
   endgenerate

   logic [5:0] fast_nx, slow_nx;

   assign fast_nx = next_entry(fast_en, fast_ptr_q);
   assign slow_nx = next_entry(slow_en, slow_ptr_q);

   // fast walker: code and slot of the entry being converted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fast_ptr_q   <= chan_select_pkg::ENTRY_NONE;
         fast_code_q  <= 6'h00;
         fast_slot_q  <= 5'h00;
         fast_valid_q <= 1'b0;
      end else if (ce) begin
         if (fast_advance || !fast_valid_q) begin
            fast_valid_q <= fast_nx[5];
            if (fast_nx[5]) begin
               fast_ptr_q  <= fast_nx[4:0];
               fast_code_q <= chan_select_pkg::ENTRY_CODE[fast_nx[4:0]];
               fast_slot_q <= slot_of(fast_nx[4:0]);
            end
         end else if (!fast_en[fast_ptr_q]) begin
            // software dropped the current channel; rescan next cycle
            fast_valid_q <= 1'b0;
         end
      end
   end

   // slow walker: shares the order, no slot output since it runs at its own rate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slow_ptr_q   <= chan_select_pkg::ENTRY_NONE;
         slow_code_q  <= 6'h00;
         slow_valid_q <= 1'b0;
      end else if (ce) begin
         if (slow_advance || !slow_valid_q) begin
            slow_valid_q <= slow_nx[5];
            if (slow_nx[5]) begin
               slow_ptr_q  <= slow_nx[4:0];
               slow_code_q <= chan_select_pkg::ENTRY_CODE[slow_nx[4:0]];
            end
         end else if (!slow_en[slow_ptr_q]) begin
            slow_valid_q <= 1'b0;
         end
      end
   end

   // calibration placement flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cal_fast_q <= 1'b0;
         cal_slow_q <= 1'b0;
      end else if (ce) begin
         cal_fast_q <= fast_en[chan_select_pkg::E_CAL];
         cal_slow_q <= slow_en[chan_select_pkg::E_CAL];
      end
   end

   assign prdata            = prdata_q;
   assign pready            = pready_q;
   assign pslverr           = pslverr_q;
   assign adc_channel_code  = fast_code_q;
   assign fast_slot         = fast_slot_q;
   assign fast_valid        = fast_valid_q;
   assign slow_channel_code = slow_code_q;
   assign slow_valid        = slow_valid_q;
   assign cal_in_fast       = cal_fast_q;
   assign cal_in_slow       = cal_slow_q;

endmodule : chan_select

`default_nettype wire

// ---- verilog/chan_select_pkg.sv ----
// constants for the monitor channel selection block
package chan_select_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_FAST_USER   = 8'h46;
   localparam logic [7:0] IDX_FAST_INT    = 8'h48;
   localparam logic [7:0] IDX_FAST_AUX    = 8'h49;
   localparam logic [7:0] IDX_SLOW_INT    = 8'h7a;
   localparam logic [7:0] IDX_SLOW_AUX    = 8'h7b;
   localparam logic [7:0] IDX_SLOW_USER   = 8'h7c;
   localparam int         IDX_LSB         = 2;

   // writable bits of each selection register; the rest read zero
   localparam logic [15:0] MASK_INT       = 16'h7fe1;
   localparam logic [15:0] MASK_AUX       = 16'hffff;
   localparam logic [15:0] MASK_USER      = 16'h000f;

   // reset values: calibration sits in the slow sequence by default
   localparam logic [15:0] RST_FAST       = 16'h0000;
   localparam logic [15:0] RST_SLOW_INT   = 16'h0001;
   localparam logic [15:0] RST_SLOW_OTHER = 16'h0000;

   // variants
   localparam logic [1:0] VAR_FIRST_GEN   = 2'h0;
   localparam logic [1:0] VAR_SECOND_GEN  = 2'h1;
   localparam logic [1:0] VAR_SECOND_PROC = 2'h2;

   // bit position of the calibration enable inside the internal register
   localparam int BIT_CAL                 = 0;

   // fixed order of sequence entries
   localparam int N_ENTRY                 = 31;
   localparam int E_CAL                   = 0;
   localparam int E_PS_FIRST              = 1;
   localparam int E_PS_LAST               = 3;

   // adc channel code of each entry in sequence order
   localparam logic [5:0] ENTRY_CODE [0:N_ENTRY-1] = '{
      6'h08, 6'h0d, 6'h0e, 6'h0f, 6'h00, 6'h01, 6'h02, 6'h03,
      6'h04, 6'h05, 6'h06,
      6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17,
      6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1c, 6'h1d, 6'h1e, 6'h1f,
      6'h20, 6'h21, 6'h22, 6'h23};

   // enable bit of each entry in the 48-bit {user, aux, internal} vector
   localparam logic [5:0] ENTRY_BIT [0:N_ENTRY-1] = '{
      6'h00, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0a, 6'h0b,
      6'h0c, 6'h0d, 6'h0e,
      6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17,
      6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1c, 6'h1d, 6'h1e, 6'h1f,
      6'h20, 6'h21, 6'h22, 6'h23};

   localparam logic [4:0] ENTRY_NONE      = 5'h00;
   localparam logic [4:0] SLOT_FIRST      = 5'h01;

endpackage : chan_select_pkg
